// >>> core/motor_hold_device.sv
// Motor controller end: trip level, hold flags, flash save, node address
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module motor_hold_device #(
    parameter int SAVE_WORD_CYCLES = `SAVE_WORD_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link to host
    motor_link_if.dev_mp link,
    // Analog readings
    input wire motor_hold_pkg::var_bank_t pot_in,
    input wire logic [`OVL_W-1:0] supply_in,
    // Internal maximum-voltage writer
    input wire logic int_ovl_wr_in,
    input wire logic [`OVL_W-1:0] int_ovl_data_in,
    // Values of neighbouring blocks to be saved, by slot
    input wire logic [15:0][15:0] ext_value_in,
    // Factory erase of the flash store
    input wire logic flash_blank_in,
    // Variable and flag state
    output motor_hold_pkg::var_bank_t var_out,
    output logic [3:0] hold_out,
    output logic [`OVL_W-1:0] ovl_out,
    output logic [`NODE_W-1:0] node_out,
    // Protection and power stage
    output logic shutdown_out,
    output logic volt_high_out,
    output logic pwm_enable_out,
    // Restored words for neighbouring blocks
    output logic restore_valid_out,
    output logic [3:0] restore_slot_out,
    output logic [15:0] restore_data_out
);
    import motor_hold_pkg::*;

    if (SAVE_WORD_CYCLES < 1 || SAVE_WORD_CYCLES > 8) begin : g_chk
        $error("SAVE_WORD_CYCLES must be 1 to 8");
    end

    localparam logic [2:0] WORD_LAST = 3'(SAVE_WORD_CYCLES - 1);
    localparam dev_regs_t DEV_RST = '{st: DEV_RELOAD, node: `NODE_RESET, default: '0};

    dev_regs_t q; // Registered state
    dev_regs_t d; // Next state
    logic take; // Frame for this node accepted
    logic trip_now; // Supply above armed level
    logic flash_wr; // Save one word this cycle
    logic [15:0] flash_rd_data; // Stored word of current slot
    logic flash_rd_saved; // Slot holds a saved word

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Lock command lists the variables in reverse order
    function automatic logic [3:0] rev4(input logic [3:0] v);
        return {v[0], v[1], v[2], v[3]};
    endfunction : rev4

    // Word written to flash for a slot
    function automatic logic [15:0] slot_value(input dev_regs_t r, input logic [3:0] s,
                                               input logic [15:0][15:0] ext);
        if (s < 4'h4) begin
            return {4'h0, r.vars[s[1:0]]};
        end else if (s == `SLOT_OVL) begin
            return {4'h0, r.ovl};
        end else if (s == `SLOT_NODE) begin
            return {9'h000, r.node};
        end
        return ext[s];
    endfunction : slot_value

    // ----------------------------------------
    // Flash store
    // ----------------------------------------
    motor_flash_store u_flash (
        .clk_in(clk_in),
        .blank_in(flash_blank_in),
        .wr_in(flash_wr),
        .wr_slot_in(q.slot),
        .wr_data_in(slot_value(q, q.slot, ext_value_in)),
        .rd_slot_in(q.slot),
        .rd_data_out(flash_rd_data),
        .rd_saved_out(flash_rd_saved)
    );

    // ----------------------------------------
    // Link handshake
    // ----------------------------------------
    // frames refused while saving
    assign link.req_ready = (q.st == DEV_IDLE);
    assign take = link.req_valid && link.req_ready && (link.req_node == q.node);
    // one word written per marked slot
    assign flash_wr = (q.st == DEV_SAVE) && q.save_map[q.slot] && (q.cnt == WORD_LAST);
    // armed only when written and held
    assign trip_now = q.ovl_written && q.ovl_hold && (supply_in > q.ovl);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;
        d.rsp_announce = 1'b0;
        d.restore_valid = 1'b0;
        d.trip = trip_now;
        if (trip_now) begin
            d.volt_high = 1'b1;
        end
        unique case (q.st)
            // Walk all slots, two cycles each for the read latency
            DEV_RELOAD: begin
                d.cnt[0] = ~q.cnt[0];
                if (q.cnt[0]) begin
                    if (flash_rd_saved) begin
                        d.restore_valid = 1'b1;
                        d.restore_slot = q.slot;
                        d.restore_data = flash_rd_data;
                        if (q.slot < 4'h4) begin
                            d.vars[q.slot[1:0]] = flash_rd_data[`OVL_W-1:0];
                            d.hold[q.slot[1:0]] = 1'b1;
                        end
                        if (q.slot == `SLOT_OVL) begin
                            d.ovl = flash_rd_data[`OVL_W-1:0];
                            d.ovl_written = 1'b1;
                            d.ovl_hold = 1'b1;
                        end
                        if (q.slot == `SLOT_NODE) begin
                            d.node = flash_rd_data[`NODE_W-1:0];
                        end
                    end
                    d.slot = q.slot + 4'h1;
                    if (q.slot == `SLOT_LAST) begin
                        d.st = DEV_ANNOUNCE;
                    end
                end
            end
            DEV_ANNOUNCE: begin
                d.rsp_valid = 1'b1;
                d.rsp_announce = 1'b1;
                d.rsp_data = {9'h000, q.node};
                d.cnt = '0;
                d.st = DEV_IDLE;
            end
            DEV_IDLE: begin
                // a moved pot overwrites the variable unless its hold flag is set
                for (int i = 0; i < 4; i++) begin
                    if (pot_in[i] != q.pot_last[i]) begin
                        d.pot_last[i] = pot_in[i];
                        if (!q.hold[i]) begin
                            d.vars[i] = pot_in[i];
                        end
                    end
                end
                if (int_ovl_wr_in) begin
                    d.ovl = int_ovl_data_in;
                end
                if (take) begin
                    if (link.req_cmd[7:2] == `CMD_VAR_WR_TOP) begin
                        d.vars[link.req_cmd[1:0]] = link.req_data[`OVL_W-1:0];
                    end else if (link.req_cmd[7:2] == `CMD_VAR_RD_TOP) begin
                        d.rsp_valid = 1'b1;
                        d.rsp_data = {4'h0, q.vars[link.req_cmd[1:0]]};
                    end else begin
                        unique case (link.req_cmd)
                            `CMD_OVL_WR: begin
                                d.ovl = link.req_data[`OVL_W-1:0];
                                d.ovl_written = 1'b1;
                            end
                            // trip level read, upper bits zero
                            `CMD_OVL_RD: begin
                                d.rsp_valid = 1'b1;
                                d.rsp_data = {4'h0, q.ovl};
                            end
                            `CMD_HOLD_SET: begin
                                d.hold = q.hold | rev4(link.req_data[3:0]);
                            end
                            `CMD_HOLD_CLR: begin
                                d.hold = q.hold & ~link.req_data[3:0];
                            end
                            `CMD_SAVE: begin
                                d.save_map = link.req_data & `SAVE_MASK;
                                d.slot = '0;
                                d.cnt = '0;
                                if ((link.req_data & `SAVE_MASK) != 16'h0000) begin
                                    d.st = DEV_SAVE;
                                end
                            end
                            // node write, then its flash save
                            `CMD_NODE_WR: begin
                                d.node = link.req_data[`NODE_W-1:0];
                                d.save_map = '0;
                                d.save_map[`SLOT_NODE] = 1'b1;
                                d.slot = '0;
                                d.cnt = '0;
                                d.st = DEV_SAVE;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            // Step through slots, program marked ones
            DEV_SAVE: begin
                if (!q.save_map[q.slot] || q.cnt == WORD_LAST) begin
                    d.cnt = '0;
                    d.slot = q.slot + 4'h1;
                    if (q.save_map[q.slot] && q.slot < 4'h4) begin
                        d.hold[q.slot[1:0]] = 1'b1;
                    end
                    if (q.save_map[q.slot] && q.slot == `SLOT_OVL) begin
                        d.ovl_hold = 1'b1;
                    end
                    if (q.slot == `SLOT_LAST) begin
                        d.st = DEV_IDLE;
                    end
                end else begin
                    d.cnt = q.cnt + 3'h1;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q <= DEV_RST;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign link.rsp_valid = q.rsp_valid;
    assign link.rsp_announce = q.rsp_announce;
    assign link.rsp_data = q.rsp_data;
    assign var_out = q.vars;
    assign hold_out = q.hold;
    assign ovl_out = q.ovl;
    assign node_out = q.node;
    assign shutdown_out = q.trip;
    assign volt_high_out = q.volt_high;
    // PWM stops during save and restart
    assign pwm_enable_out = (q.st == DEV_IDLE) && !q.trip;
    assign restore_valid_out = q.restore_valid;
    assign restore_slot_out = q.restore_slot;
    assign restore_data_out = q.restore_data;
endmodule : motor_hold_device

`default_nettype wire

// >>> inc/motor_hold_defs.svh
// Command codes, field layout, timing and host register map of the hold/save logic
`ifndef MOTOR_HOLD_DEFS_SVH
`define MOTOR_HOLD_DEFS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CLK_PERIOD_NS 20

// ----------------------------------------
// Link command codes
// ----------------------------------------
`define CMD_OVL_WR 8'h08
`define CMD_OVL_RD 8'h48
`define CMD_HOLD_SET 8'h20
`define CMD_HOLD_CLR 8'h21
`define CMD_SAVE 8'h22
`define CMD_NODE_WR 8'h26
// Upper six bits of the per-variable write and read codes, low two bits pick the variable
`define CMD_VAR_WR_TOP 6'h00
`define CMD_VAR_RD_TOP 6'h10

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define OVL_W 12
`define NODE_W 7
`define NODE_RESET 7'h00
`define SAVE_MASK 16'h21ff
`define SLOT_OVL 4'h8
`define SLOT_NODE 4'he
`define SLOT_LAST 4'hf

// ----------------------------------------
// Timing
// ----------------------------------------
`define SAVE_WORD_NS 100
`define SAVE_WORD_CYC ((`SAVE_WORD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAVE_LIMIT 10000

// ----------------------------------------
// Host register map
// ----------------------------------------
`define HOST_TARGET 8'h00
`define HOST_DATA 8'h04
`define HOST_STATUS 8'h08
`define HOST_RESP 8'h0c
`define HOST_ANNOUNCE 8'h10

`endif

// >>> inc/motor_hold_pkg.sv
// Types shared by both ends of the hold/save link
package motor_hold_pkg;
`include "motor_hold_defs.svh"

    // Four pot-driven variables: 0 speed, 1 current, 2 regen, 3 accel
    typedef logic [3:0][`OVL_W-1:0] var_bank_t;

    typedef enum logic [1:0] {DEV_RELOAD, DEV_ANNOUNCE, DEV_IDLE, DEV_SAVE} dev_state_t;
    typedef enum logic {H_IDLE, H_SEND} host_state_t;

    // Whole state of the device end
    typedef struct packed {
        dev_state_t st;
        logic [3:0] slot;
        logic [2:0] cnt;
        logic [15:0] save_map;
        logic [`NODE_W-1:0] node;
        logic [`OVL_W-1:0] ovl;
        logic ovl_written;
        logic ovl_hold;
        logic [3:0] hold;
        var_bank_t vars;
        var_bank_t pot_last;
        logic trip;
        logic volt_high;
        logic rsp_valid;
        logic rsp_announce;
        logic [15:0] rsp_data;
        logic restore_valid;
        logic [3:0] restore_slot;
        logic [15:0] restore_data;
    } dev_regs_t;

    // Whole state of the host end
    typedef struct packed {
        host_state_t st;
        logic [`NODE_W-1:0] node;
        logic [7:0] cmd;
        logic [15:0] data;
        logic [15:0] resp;
        logic resp_new;
        logic [`NODE_W-1:0] ann_id;
        logic ann_seen;
        logic refused;
        logic [13:0] saves;
        logic [15:0] rdata;
    } host_regs_t;

    // Non-volatile state of the flash store
    typedef struct packed {
        logic [15:0] saved;
        logic [15:0] rd_data;
    } flash_regs_t;

endpackage : motor_hold_pkg

// >>> inc/motor_link_if.sv
// Frame link between host controller and motor controller
`timescale 1ns/10ps
`default_nettype none

interface motor_link_if;
    logic req_valid;
    logic req_ready;
    logic [6:0] req_node;
    logic [7:0] req_cmd;
    logic [15:0] req_data;
    logic rsp_valid;
    logic rsp_announce;
    logic [15:0] rsp_data;

    modport dev_mp (
        input req_valid, req_node, req_cmd, req_data,
        output req_ready, rsp_valid, rsp_announce, rsp_data
    );
    modport host_mp (
        output req_valid, req_node, req_cmd, req_data,
        input req_ready, rsp_valid, rsp_announce, rsp_data
    );
endinterface : motor_link_if

`default_nettype wire

// >>> core/motor_flash_store.sv
// Sixteen-word non-volatile store with a saved bit per slot
`timescale 1ns/10ps
`default_nettype none

module motor_flash_store (
    // Clock and factory erase
    input wire logic clk_in,
    input wire logic blank_in,
    // Write port
    input wire logic wr_in,
    input wire logic [3:0] wr_slot_in,
    input wire logic [15:0] wr_data_in,
    // Read port, data one cycle later
    input wire logic [3:0] rd_slot_in,
    output logic [15:0] rd_data_out,
    output logic rd_saved_out
);
    import motor_hold_pkg::*;

    // Word array; keeps its content through restart
    logic [15:0] mem [16];
    flash_regs_t q;
    flash_regs_t d;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        d = q;
        d.rd_data = mem[rd_slot_in];
        // Erase wins over a write in the same cycle
        if (wr_in) begin
            d.saved[wr_slot_in] = 1'b1;
        end
        if (blank_in) begin
            d.saved = '0;
        end
    end

    // No reset: contents must survive a restart
    always_ff @(posedge clk_in) begin
        q <= d;
        if (wr_in) begin
            mem[wr_slot_in] <= wr_data_in;
        end
    end

    assign rd_data_out = q.rd_data;
    assign rd_saved_out = q.saved[rd_slot_in];
endmodule : motor_flash_store

`default_nettype wire

// >>> core/motor_hold_host.sv
// Host controller end: register port in, command frames out
`timescale 1ns/10ps
`default_nettype none

module motor_hold_host #(
    parameter int SAVE_LIMIT = `SAVE_LIMIT
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Software register port
    input wire logic [7:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    // Link to controller
    motor_link_if.host_mp link
);
    import motor_hold_pkg::*;

    if (SAVE_LIMIT < 1 || SAVE_LIMIT > 16383) begin : g_chk
        $error("SAVE_LIMIT must be 1 to 16383");
    end

    localparam logic [13:0] SAVE_MAX = 14'(SAVE_LIMIT);

    host_regs_t q; // Registered state
    host_regs_t d; // Next state

    // Commands that wear the flash
    function automatic logic is_save(input logic [7:0] c);
        return (c == `CMD_SAVE) || (c == `CMD_NODE_WR);
    endfunction : is_save

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        d = q;
        d.rdata = '0;
        // Register reads, answered next cycle; clears come before sets
        if (rd_in) begin
            unique case (addr_in)
                `HOST_TARGET: d.rdata = {q.cmd, 1'b0, q.node};
                `HOST_STATUS: begin
                    d.rdata = {12'h000, q.refused, q.ann_seen, q.resp_new, q.st == H_SEND};
                    d.refused = 1'b0;
                end
                `HOST_RESP: begin
                    d.rdata = q.resp;
                    d.resp_new = 1'b0;
                end
                `HOST_ANNOUNCE: d.rdata = {9'h000, q.ann_id};
                default: d.rdata = '0;
            endcase
        end
        // Frame leaves once the controller is ready
        if (q.st == H_SEND && link.req_ready) begin
            d.st = H_IDLE;
        end
        // Register writes; target stays put while a frame waits
        if (wr_in && addr_in == `HOST_TARGET) begin
            if (q.st == H_SEND) begin
                d.refused = 1'b1;
            end else begin
                d.node = wdata_in[6:0];
                d.cmd = wdata_in[15:8];
            end
        end
        if (wr_in && addr_in == `HOST_DATA) begin
            // stop saving once the wear budget is spent
            if (q.st == H_SEND || (is_save(q.cmd) && q.saves == SAVE_MAX)) begin
                d.refused = 1'b1;
            end else begin
                d.data = wdata_in;
                d.st = H_SEND;
                if (is_save(q.cmd)) begin
                    d.saves = q.saves + 14'h0001;
                end
            end
        end
        // Answers and the start-up announcement
        if (link.rsp_valid) begin
            if (link.rsp_announce) begin
                d.ann_id = link.rsp_data[6:0];
                d.ann_seen = 1'b1;
            end else begin
                d.resp = link.rsp_data;
                d.resp_new = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q <= '{st: H_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rdata_out = q.rdata;
    assign link.req_valid = (q.st == H_SEND);
    assign link.req_node = q.node;
    assign link.req_cmd = q.cmd;
    assign link.req_data = q.data;
endmodule : motor_hold_host

`default_nettype wire

// >>> verif/motor_link_props.sv
// Checker for the frame link between host and motor controller
`timescale 1ns/10ps
`default_nettype none

module motor_link_props (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link signals
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [6:0] req_node,
    input wire logic [7:0] req_cmd,
    input wire logic [15:0] req_data,
    input wire logic rsp_valid,
    input wire logic rsp_announce,
    input wire logic [15:0] rsp_data
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic take;
    // Own address, kept over reset like its stored copy
    logic [6:0] node_q = 7'h00;
    // Cycles since reset release, saturating
    logic [5:0] cnt_q;

    assign take = req_valid && req_ready && (req_node == node_q);

    // Follow address writes that reach this node
    always_ff @(posedge clk_in) begin
        if (take && req_cmd == 8'h26) begin
            node_q <= req_data[6:0];
        end
    end

    // Count up after reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= 6'h00;
        end else if (cnt_q != 6'h3f) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_READ_ANSWER: assert property (
        take && req_cmd == 8'h48 |=> rsp_valid && !rsp_announce && rsp_data[15:12] == 4'h0)
        else $error("level read gave no clean answer");
    AST_WRITE_SILENT: assert property (take && req_cmd[7:6] == 2'b00 |=> !rsp_valid)
        else $error("write or unknown code answered");
    AST_ANSWER_CAUSE: assert property (rsp_valid && !rsp_announce |-> $past(take))
        else $error("answer without own request");
    AST_SAVE_STALL: assert property (
        take && req_cmd == 8'h22 && (req_data & 16'h21ff) != 16'h0000 |=> !req_ready [*8])
        else $error("frames accepted during save");
    AST_SAVE_ENDS: assert property (take && req_cmd == 8'h22 |=> ##[1:200] req_ready)
        else $error("save never finished");
    AST_NODE_SAVE: assert property (take && req_cmd == 8'h26 |=> !req_ready)
        else $error("address write not stored");
    AST_RELOAD_QUIET: assert property (cnt_q < 6'd30 |-> !req_ready && !rsp_valid)
        else $error("link active during reload");
    AST_ANNOUNCE_ID: assert property (
        rsp_announce |-> rsp_valid && rsp_data == {9'h000, node_q} && cnt_q >= 6'd30 && cnt_q <= 6'd36)
        else $error("bad start announcement");
    AST_REQ_HOLD: assert property (
        req_valid && !req_ready |=> req_valid && $stable(req_node) && $stable(req_cmd) && $stable(req_data))
        else $error("request dropped before taken");
endmodule : motor_link_props

`default_nettype wire

// >>> verif/tb.sv
// Bench for host and controller joined by the frame link
`timescale 1ns/10ps
`default_nettype none

module tb;
    import motor_hold_pkg::*;
    logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, blank = 1, iw = 0, shut, vhigh, pwm;
    logic [7:0] addr_in = 0;
    logic [15:0] wdata_in = 0, rdata_out, v;
    logic [11:0] supply = 0, idat = 0, ovl_out;
    var_bank_t pot = '0, var_out;
    logic [3:0] hold_out;
    logic [6:0] node_out;
    logic [3:0] rs;
    logic [15:0] rdd;
    logic rv;
    int num_errors = 0, compares = 0, cyc = 0, nrest = 0;

    motor_link_if lk ();
    motor_hold_host #(.SAVE_LIMIT(4)) motor_hold_host_i (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .link(lk));
    motor_hold_device #(.SAVE_WORD_CYCLES(5)) motor_hold_device_i (.clk_in, .rst_in, .link(lk), .pot_in(pot),
        .supply_in(supply), .int_ovl_wr_in(iw), .int_ovl_data_in(idat), .ext_value_in('0), .flash_blank_in(blank),
        .var_out, .hold_out, .ovl_out, .node_out, .shutdown_out(shut), .volt_high_out(vhigh),
        .pwm_enable_out(pwm), .restore_valid_out(rv), .restore_slot_out(rs), .restore_data_out(rdd));
    motor_link_props motor_link_props_i (.clk_in, .rst_in, .req_valid(lk.req_valid), .req_ready(lk.req_ready),
        .req_node(lk.req_node), .req_cmd(lk.req_cmd), .req_data(lk.req_data), .rsp_valid(lk.rsp_valid),
        .rsp_announce(lk.rsp_announce), .rsp_data(lk.rsp_data));

    // 20 ns clock
    always #10 clk_in = ~clk_in;

    // Hang guard
    always @(posedge clk_in) begin
        cyc++;
        // Count restored words
        if (rv === 1'b1) begin
            nrest++;
        end
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(posedge clk_in);
        #1;
    endtask : wr

    // Read data stands in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
        @(posedge clk_in);
        #1;
    endtask : rd

    // Launch a frame and wait until it leaves the host
    task automatic send(input logic [7:0] c, input logic [6:0] n, input logic [15:0] d);
        wr(8'h00, {c, 1'b0, n});
        wr(8'h04, d);
        for (int i = 0; i < 100; i++) begin
            rd(8'h08);
            if (v[0] === 1'b0) break;
        end
        chk({15'h0, v[0]}, 16'h0000);
    endtask : send

    task automatic idle();
        repeat (300) if (lk.req_ready !== 1'b1) @(posedge clk_in);
        #3;
        chk({15'h0, lk.req_ready}, 16'h0001);
    endtask : idle

    task automatic tk();
        repeat (3) @(posedge clk_in);
        #1;
    endtask : tk

    task automatic boot();
        rst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        blank <= 1'b0;
        repeat (40) @(posedge clk_in);
        #1;
    endtask : boot

    initial begin
        boot();
        rd(8'h08); chk(v, 16'h0004);
        rd(8'h10); chk(v, 16'h0000);
        send(8'h08, 7'h00, 16'hf123); send(8'h48, 7'h00, 16'h0000); idle();
        rd(8'h0c); chk(v, 16'h0123);
        // Internal writer, then over-limit supply while unarmed
        iw <= 1'b1; idat <= 12'h150; supply <= 12'h200; @(posedge clk_in); iw <= 1'b0; tk();
        chk({4'h0, ovl_out}, 16'h0150); chk({15'h0, shut}, 16'h0000);
        send(8'h22, 7'h00, 16'h0100); chk({15'h0, pwm}, 16'h0000); idle(); tk();
        chk({14'h0, shut, vhigh}, 16'h0003); chk({15'h0, pwm}, 16'h0000);
        supply <= 12'h100; tk(); chk({14'h0, shut, vhigh}, 16'h0001);
        pot <= {4{12'h111}}; tk();
        for (int k = 0; k < 4; k++) begin
            chk({4'h0, var_out[k]}, 16'h0111);
            send(8'h20, 7'h00, 16'hfff0 | (16'h0008 >> k)); tk(); chk({12'h0, hold_out}, 16'h0001 << k);
            pot[k] <= 12'h222; tk(); chk({4'h0, var_out[k]}, 16'h0111);
            send({6'h00, k[1:0]}, 7'h00, 16'h0333); tk(); chk({4'h0, var_out[k]}, 16'h0333);
            send(8'h21, 7'h00, 16'h0001 << k); tk(); chk({12'h0, hold_out}, 16'h0000);
            pot[k] <= 12'h111; tk(); chk({4'h0, var_out[k]}, 16'h0111);
        end
        send(8'h22, 7'h00, 16'h0000); idle(); chk({12'h0, hold_out}, 16'h0000);
        send(8'h22, 7'h00, 16'h0002); idle(); chk({12'h0, hold_out}, 16'h0002);
        send(8'h08, 7'h05, 16'h0777); send(8'h09, 7'h00, 16'hffff); tk(); chk({4'h0, ovl_out}, 16'h0150);
        send(8'h26, 7'h00, 16'hff85); idle(); chk({9'h0, node_out}, 16'h0005);
        // Fifth wearing command is refused by the host
        send(8'h22, 7'h05, 16'h0001); chk(v, 16'h000c);
        // Restart restores address, level and held variable
        pot[1] <= 12'h222; supply <= 12'h000; boot();
        rd(8'h10); chk(v, 16'h0005);
        chk({4'h0, ovl_out}, 16'h0150); chk({4'h0, var_out[1]}, 16'h0111);
        chk({12'h0, hold_out}, 16'h0002);
        chk(nrest[15:0], 16'h0003); chk(rdd, 16'h0005); chk({12'h0, rs}, 16'h000e);
        send(8'h48, 7'h05, 16'h0000); idle(); rd(8'h0c); chk(v, 16'h0150);
        end_sim();
    end
endmodule : tb

`default_nettype wire
